// ### asrp_host_model.sv
module asrp_host_model
  import asrp_pkg::*;
(
  // clock
  input  wire logic                 mclk,
  // device pins
  input  wire asrp_pkg::asrp_pins_s pins,
  input  wire logic                 invert,
  // host serial drive
  output logic                      converterSelectN,
  output logic                      serialClockIn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    converterSelectN = 1'b1;
    serialClockIn = 1'b0;
  end

  task automatic slaveRead(input int n, output logic [31:0] word);
    word = '0;
    @(posedge mclk) serialClockIn <= ~invert;
    repeat (3) @(posedge mclk);
    @(posedge mclk) serialClockIn <= invert;
    repeat (3) @(posedge mclk);
    @(posedge mclk) converterSelectN <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk) serialClockIn <= ~invert;
      repeat (3) @(posedge mclk);
      @(negedge mclk) word = {word[30:0], pins.serialDataOutput};
      @(posedge mclk) serialClockIn <= invert;
      repeat (2) @(posedge mclk);
    end
    @(posedge mclk) converterSelectN <= 1'b1;
  endtask

  // samples data at each falling phase, measures the bit period
  task automatic masterCapture(input logic act, output logic [15:0] word,
                               output int period, output logic ok);
    logic prev;
    int n;
    int last;
    prev = 1'b0;
    n = 0;
    last = 0;
    ok = 1'b1;
    word = '0;
    period = 0;
    for (int t = 0; t < 400 && n < 16; t++) begin
      @(negedge mclk);
      if (prev && !(pins.serialClockOut ^ invert)) begin
        word = {word[14:0], pins.serialDataOutput};
        if (n > 0) period = t - last;
        last = t;
        n++;
      end
      if (n > 0 && n <= 16 && pins.frameSync !== act) ok = 1'b0;
      prev = pins.serialClockOut ^ invert;
    end
  endtask
endmodule // asrp_host_model

// ### asrp_map.svh
`ifndef ASRP_MAP_SVH
`define ASRP_MAP_SVH
// bits in one conversion result
`define ASRP_WORD_BITS 16
// result register reset value
`define ASRP_RESULT_RST 16'h0000
// bit position of the last shift count
`define ASRP_LAST_BIT 5'h0F
// low parallel nibble position carried by the shared pins
`define ASRP_PAR_LSB 4
`endif

// ### asrp_pkg.sv
`include "asrp_map.svh"
package asrp_pkg;
  typedef enum logic [0:0] {
    ASRP_IDLE  = 1'b0,
    ASRP_SHIFT = 1'b1
  } asrp_state_e;

  typedef logic [`ASRP_WORD_BITS-1:0] asrp_word_t;

  // serial configuration straps shared with parallel bits
  typedef struct packed {
    logic       serialParallelSelect;
    logic       clockSourceSelect;
    logic [1:0] serialClockDivider;
    logic       frameSyncPolarity;
    logic       serialClockInvert;
    logic       readModeOrChainInput;
  } asrp_cfg_s;

  // pins driven toward the host
  typedef struct packed {
    logic       serialClockOut;
    logic       serialClockOe;
    logic       serialDataOutput;
    logic       frameSync;
    logic [3:0] parData;
    logic       parDataOe;
  } asrp_pins_s;
endpackage : asrp_pkg

// ### asrp_serial_read_port.sv
`include "asrp_map.svh"
// Operation
// - divider slows internal bit clock only in master read-after-conversion mode
// - parallel mode drives result bits 4 to 7 on shared pins
// - clock source low makes master clock out; high shifts on host clock
// - host clock accepted only while converter select is asserted
// - frame sync polarity low gives active-high sync, high gives active-low
// - clock invert flips bit clock polarity in master and slave
// - slave chain input appears on data output 16 bit clocks later
// - master with read mode high shifts previous result during conversion
// - master with read mode low shifts result after conversion completes
// - serial select low enables parallel port, high enables serial port
// - data output shifts stored result most significant bit first
// - slave data changes on update edge, valid on following edge
// - master frame sync active for whole valid data period
module asrp_serial_read_port
  import asrp_pkg::*;
(
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // converter core
  input  wire logic               convStart,
  input  wire logic               convDone,
  input  wire asrp_pkg::asrp_word_t convResult,
  // configuration straps
  input  wire asrp_pkg::asrp_cfg_s cfg,
  // host serial side
  input  wire logic               converterSelectN,
  input  wire logic               serialClockIn,
  // pins
  output asrp_pkg::asrp_pins_s    pins
);
  import asrp_pkg::*;

  asrp_state_e st_r,     st_nxt;
  asrp_word_t  result_r, result_nxt;
  asrp_word_t  sr_r,     sr_nxt;
  logic [4:0]  cnt_r,    cnt_nxt;
  logic [3:0]  div_r,    div_nxt;
  logic        phase_r,  phase_nxt;
  logic        sclkPrev_r, sclkPrev_nxt;
  logic        csPrevN_r,  csPrevN_nxt;
  asrp_pins_s  pins_r,   pins_nxt;

  logic master;
  logic slave;
  logic slaveClk;
  logic slaveUpd;
  logic slaveStart;
  logic tick;
  logic startEv;

  function automatic logic [3:0] half_period(input logic [1:0] dv, input logic rac);
    half_period = rac ? 4'((1 << dv) - 1) : 4'h0;
  endfunction

  assign master   = cfg.serialParallelSelect & ~cfg.clockSourceSelect;
  assign slave    = cfg.serialParallelSelect & cfg.clockSourceSelect;
  assign slaveClk = serialClockIn ^ cfg.serialClockInvert;
  assign slaveUpd = slave & ~converterSelectN & slaveClk & ~sclkPrev_r;
  assign slaveStart = slave & ~converterSelectN & csPrevN_r;
  assign tick     = (div_r == 4'h0);
  // read-during-conversion starts at conversion start, else at completion
  assign startEv  = master & (cfg.readModeOrChainInput ? convStart : convDone);

  always_comb begin
    st_nxt       = st_r;
    result_nxt   = result_r;
    sr_nxt       = sr_r;
    cnt_nxt      = cnt_r;
    div_nxt      = div_r;
    phase_nxt    = phase_r;
    sclkPrev_nxt = slaveClk;
    csPrevN_nxt  = converterSelectN;
    pins_nxt     = pins_r;
    if (convDone) begin
      result_nxt = convResult;
    end
    if (master) begin
      unique case (st_r)
        ASRP_IDLE: begin
          phase_nxt = 1'b0;
          if (startEv) begin
            st_nxt  = ASRP_SHIFT;
            sr_nxt  = cfg.readModeOrChainInput ? result_r : convResult;
            cnt_nxt = 5'h00;
            div_nxt = half_period(cfg.serialClockDivider, ~cfg.readModeOrChainInput);
          end
        end
        ASRP_SHIFT: begin
          if (tick) begin
            div_nxt   = half_period(cfg.serialClockDivider, ~cfg.readModeOrChainInput);
            phase_nxt = ~phase_r;
            if (!phase_r) begin
              pins_nxt.serialDataOutput = sr_r[`ASRP_WORD_BITS-1];
              sr_nxt = {sr_r[`ASRP_WORD_BITS-2:0], 1'b0};
            end else begin
              cnt_nxt = 5'(cnt_r + 5'h01);
              if (cnt_r == `ASRP_LAST_BIT) begin
                st_nxt = ASRP_IDLE;
              end
            end
          end else begin
            div_nxt = 4'(div_r - 4'h1);
          end
        end
      endcase
    end else if (slave) begin
      phase_nxt = 1'b0;
      if (converterSelectN) begin
        st_nxt = ASRP_IDLE;
      end else if (slaveStart) begin
        st_nxt = ASRP_SHIFT;
        sr_nxt = result_r;
      end else if (slaveUpd) begin
        // chain bit enters at the bottom, emerges 16 updates later
        pins_nxt.serialDataOutput = sr_r[`ASRP_WORD_BITS-1];
        sr_nxt = {sr_r[`ASRP_WORD_BITS-2:0], cfg.readModeOrChainInput};
      end
    end else begin
      st_nxt    = ASRP_IDLE;
      phase_nxt = 1'b0;
    end
    pins_nxt.serialClockOut = phase_nxt ^ cfg.serialClockInvert;
    pins_nxt.serialClockOe  = master;
    // sync held through the last falling edge, where the host takes bit 0
    pins_nxt.frameSync = (master & ((st_nxt == ASRP_SHIFT) | (st_r == ASRP_SHIFT)))
                         ^ cfg.frameSyncPolarity;
    pins_nxt.parData   = result_nxt[`ASRP_PAR_LSB +: 4];
    pins_nxt.parDataOe = ~cfg.serialParallelSelect;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r       <= ASRP_IDLE;
      result_r   <= `ASRP_RESULT_RST;
      sr_r       <= `ASRP_RESULT_RST;
      cnt_r      <= 5'h00;
      div_r      <= 4'h0;
      phase_r    <= 1'b0;
      sclkPrev_r <= 1'b0;
      csPrevN_r  <= 1'b1;
      pins_r     <= '0;
    end else begin
      st_r       <= st_nxt;
      result_r   <= result_nxt;
      sr_r       <= sr_nxt;
      cnt_r      <= cnt_nxt;
      div_r      <= div_nxt;
      phase_r    <= phase_nxt;
      sclkPrev_r <= sclkPrev_nxt;
      csPrevN_r  <= csPrevN_nxt;
      pins_r     <= pins_nxt;
    end
  end

  assign pins = pins_r;

  a_div_ignored: assert property (@(posedge mclk) disable iff (rst)
    master && cfg.readModeOrChainInput && st_r == ASRP_SHIFT
      && $past(st_r) == ASRP_SHIFT
    |-> phase_r != $past(phase_r))
    else $error("divider applied outside read-after-conversion");

  a_div_slows: assert property (@(posedge mclk) disable iff (rst)
    master && st_r == ASRP_SHIFT && div_r != 4'h0 |=> phase_r == $past(phase_r))
    else $error("bit clock toggled before divider expired");

  a_par_data_bits: assert property (@(posedge mclk) disable iff (rst)
    !rst && !cfg.serialParallelSelect ##1 !$past(convDone)
    |-> pins.parDataOe && pins.parData == result_r[`ASRP_PAR_LSB +: 4])
    else $error("parallel bits 4 to 7 wrong");

  a_clk_source: assert property (@(posedge mclk) disable iff (rst)
    cfg.serialParallelSelect |=> pins.serialClockOe == !$past(cfg.clockSourceSelect))
    else $error("clock pin drive does not follow clock source");

  a_slave_gate: assert property (@(posedge mclk) disable iff (rst)
    slave && converterSelectN |=> $stable(sr_r) && st_r == ASRP_IDLE)
    else $error("host clock accepted while deselected");

  a_sync_idle: assert property (@(posedge mclk) disable iff (rst)
    master && st_r == ASRP_IDLE && !startEv
    |=> pins.frameSync == $past(cfg.frameSyncPolarity))
    else $error("idle frame sync level wrong");

  a_clk_invert: assert property (@(posedge mclk) disable iff (rst)
    master |=> pins.serialClockOut == (phase_r ^ $past(cfg.serialClockInvert)))
    else $error("bit clock polarity wrong");

  a_chain_in: assert property (@(posedge mclk) disable iff (rst)
    slaveUpd && !slaveStart |=> sr_r[0] == $past(cfg.readModeOrChainInput))
    else $error("chain input not captured");

  a_rdc_start: assert property (@(posedge mclk) disable iff (rst)
    master && cfg.readModeOrChainInput && convStart && st_r == ASRP_IDLE
    |=> st_r == ASRP_SHIFT && sr_r == $past(result_r))
    else $error("previous result not loaded at conversion start");

  a_rac_start: assert property (@(posedge mclk) disable iff (rst)
    master && !cfg.readModeOrChainInput && convDone && st_r == ASRP_IDLE
    |=> st_r == ASRP_SHIFT && sr_r == $past(convResult))
    else $error("new result not loaded at completion");

  a_serial_par_off: assert property (@(posedge mclk) disable iff (rst)
    cfg.serialParallelSelect |=> !pins.parDataOe)
    else $error("parallel port driven in serial mode");

  a_msb_first: assert property (@(posedge mclk) disable iff (rst)
    slaveUpd && !slaveStart |=> pins.serialDataOutput == $past(sr_r[15]))
    else $error("data output not msb of shift register");

  a_sync_during: assert property (@(posedge mclk) disable iff (rst)
    st_r == ASRP_SHIFT && $past(master) && $past(cfg.frameSyncPolarity) == cfg.frameSyncPolarity
    |-> pins.frameSync == !cfg.frameSyncPolarity)
    else $error("frame sync inactive during read");

  a_sync_tail: assert property (@(posedge mclk) disable iff (rst)
    master && st_r == ASRP_SHIFT ##1 st_r == ASRP_IDLE
    |-> pins.frameSync == !cfg.frameSyncPolarity)
    else $error("frame sync dropped before last bit sampled");

  a_master_data_hold: assert property (@(posedge mclk) disable iff (rst)
    master && st_r == ASRP_SHIFT && !(tick && !phase_r)
    |=> $stable(pins.serialDataOutput))
    else $error("data output changed away from bit clock update");

  a_slave_sync_off: assert property (@(posedge mclk) disable iff (rst)
    slave |=> pins.frameSync == $past(cfg.frameSyncPolarity))
    else $error("frame sync active in slave mode");
endmodule // asrp_serial_read_port

// ### asrp_serial_read_port_bench.sv
module asrp_serial_read_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import asrp_pkg::*;

  logic       mclk, rst, convStart, convDone, converterSelectN, serialClockIn;
  asrp_word_t convResult;
  asrp_cfg_s  cfg;
  asrp_pins_s pins;
  int         miscompares, totalChecks;

  asrp_serial_read_port asrp_serial_read_port_inst (.mclk(mclk), .rst(rst),
    .convStart(convStart), .convDone(convDone), .convResult(convResult), .cfg(cfg),
    .converterSelectN(converterSelectN), .serialClockIn(serialClockIn), .pins(pins));
  asrp_host_model asrp_host_model_inst (.mclk(mclk), .pins(pins),
    .invert(cfg.serialClockInvert), .converterSelectN(converterSelectN),
    .serialClockIn(serialClockIn));

  always #4 mclk = ~mclk;

  task automatic stopTest();
    $display("checks=%0d mismatches=%0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic pulse(input logic done, input asrp_word_t val);
    @(posedge mclk) begin
      convDone <= done;
      convStart <= !done;
      convResult <= val;
    end
    @(posedge mclk) begin
      convDone <= 1'b0;
      convStart <= 1'b0;
    end
  endtask

  task automatic masterRead(input logic rm, input logic [1:0] dv, input logic sp,
                            input logic inv, input asrp_word_t val);
    logic [15:0] w;
    int          per;
    logic        ok;
    @(posedge mclk) cfg <= '{1'b1, 1'b0, dv, sp, inv, rm};
    repeat (2) @(posedge mclk);
    if (!rm) pulse(1'b0, 16'h0000);
    @(negedge mclk) check(pins.frameSync, sp);
    pulse(1'b1, val);
    if (rm) pulse(1'b0, 16'h0000);
    asrp_host_model_inst.masterCapture(!sp, w, per, ok);
    check(w, val);
    check(per, rm ? 32'h2 : 32'h2 << dv);
    check(ok, 1'b1);
    repeat (4) @(posedge mclk);
    @(negedge mclk) check(pins.frameSync, sp);
    check(pins.serialClockOe, 1'b1);
    $display("test master mode=%0d div=%0d done", rm, dv);
  endtask

  task automatic slaveRead(input logic inv, input logic chain, input asrp_word_t val);
    logic [31:0] w;
    @(posedge mclk) cfg <= '{1'b1, 1'b1, 2'b00, 1'b0, inv, chain};
    pulse(1'b1, val);
    asrp_host_model_inst.slaveRead(17, w);
    check(w, {15'h0000, val, chain});
    @(negedge mclk) check(pins.serialClockOe, 1'b0);
    $display("test slave invert=%0d done", inv);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    stopTest();
  end

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    convStart = 1'b0;
    convDone = 1'b0;
    convResult = '0;
    cfg = '0;
    miscompares = 0;
    totalChecks = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    pulse(1'b1, 16'hA5C3);
    repeat (2) @(posedge mclk);
    @(negedge mclk) check(pins.parData, 4'hC);
    check(pins.parDataOe, 1'b1);
    $display("test parallel done");
    masterRead(1'b0, 2'b00, 1'b0, 1'b0, 16'h8001);
    masterRead(1'b0, 2'b01, 1'b1, 1'b0, 16'h7FFE);
    masterRead(1'b0, 2'b10, 1'b0, 1'b1, 16'h3C96);
    masterRead(1'b0, 2'b11, 1'b1, 1'b1, 16'hA5C3);
    masterRead(1'b1, 2'b11, 1'b0, 1'b1, 16'h5A0F);
    slaveRead(1'b0, 1'b1, 16'hC33C);
    slaveRead(1'b1, 1'b0, 16'h9669);
    stopTest();
  end
endmodule // asrp_serial_read_port_bench
